// *** core/fsk_modem_pins.sv ***
// Summary of operation
// - Modulator and transmit output run only while request to send is low.
// - Low transmit bit gives 2200 Hz, high gives 1200 Hz.
// - Receive bit high for 1200 Hz tone, low for 2200 Hz.
// - Receive bit passes only while carrier is present, else low.
// - Qualified receive bit is not carrier or receive bit.
// - Carrier present rises after four consecutive threshold pulses.
// - Reset low holds all logic in reset.
// - Transmit level sits at idle code while request to send high.
// - Configuration frames of 8 or 16 bits are both accepted.
// - On fault the DAC output jumps to the alarm level pin.
// - Watchdog kicked by internal 1.8 kHz tick or external pin.
// - Aux and core clock outputs divided by configuration fields.
// - DAC pin driven by 16-bit sigma-delta modulator.
// - Tone phase continues across mark and space switching.
// - Carrier drops if next pulse misses the 2.5 ms gap.
// - Carrier present only while request to send is high.
`default_nettype none
module fsk_modem_pins #(
   parameter int unsigned CD_GAP_CYC       = modem_pkg::CD_GAP_CYC,
   parameter int unsigned WDOG_TICK_CYC    = modem_pkg::WDOG_TICK_CYC,
   parameter int unsigned WDOG_TIMEOUT_CYC = modem_pkg::WDOG_TIMEOUT_CYC
) (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        request_to_send_n_i,
   input  wire logic        tx_bit_i,
   input  wire logic        rx_cmp_i,
   input  wire logic        carrier_cmp_i,
   input  wire logic        serial_clock_i,
   input  wire logic        spi_select_i,
   input  wire logic        serial_data_i,
   input  wire logic        alarm_level_select_i,
   input  wire logic        watchdog_tick_i,
   output logic             mod_enable_o,
   output modem_pkg::level_t mod_level_o,
   output logic             rx_bit_o,
   output logic             rx_bit_qualified_o,
   output logic             carrier_present_o,
   output logic             aux_clock_o,
   output logic             core_clock_o,
   output logic             dac_o,
   output logic             watchdog_fault_o,
   output logic             cfg_drop_o
);
   import modem_pkg::*;

   // ****************************************
   // Configuration path
   // ****************************************
   frame_if #(.W(FRAME_W)) cfg_bus ();
   frame_if #(.W(FRAME_W)) drain_bus ();

   logic        drop_pulse;
   logic [7:0]  cfg_r;
   logic [15:0] dac_code_r;
   logic [7:0]  upd_cnt_r;
   logic        upd_tick;
   logic        pop;

   cfg_shift u_cfg_shift (
      .ref_clk_i      (ref_clk_i),
      .rst_b_i        (rst_b_i),
      .serial_clock_i (serial_clock_i),
      .spi_select_i   (spi_select_i),
      .serial_data_i  (serial_data_i),
      .out_p          (cfg_bus.src),
      .drop_o         (drop_pulse)
   );

   frame_fifo #(
      .W     (FRAME_W),
      .DEPTH (FIFO_DEPTH)
   ) u_frame_fifo (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .in_p      (cfg_bus.snk),
      .out_p     (drain_bus.src)
   );

   // One frame applied per update slot; lets the buffer fill under bursts
   assign upd_tick        = (upd_cnt_r == DAC_UPDATE_CYC);
   assign drain_bus.ready = upd_tick;
   assign pop             = upd_tick && drain_bus.valid;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         upd_cnt_r  <= '0;
         cfg_r      <= CFG_RESET;
         dac_code_r <= DAC_RESET;
         cfg_drop_o <= 1'b0;
      end else begin
         upd_cnt_r  <= upd_cnt_r + 8'h01;
         cfg_drop_o <= drop_pulse;
         // long frame loads DAC, short frame loads config
         if (pop && drain_bus.data[FRAME_LONG_BIT]) begin
            dac_code_r <= drain_bus.data[15:0];
         end else if (pop) begin
            cfg_r <= drain_bus.data[7:0];
         end
      end
   end

   // ****************************************
   // Tone generator
   // ****************************************
   logic [23:0] phase_r;
   logic [23:0] phase_inc;
   logic [23:0] phase_nxt;
   logic [6:0]  tri_val;
   level_t      level_nxt;

   // mark for high bit, space for low
   assign phase_inc = tx_bit_i ? MARK_INC : SPACE_INC;
   // accumulator never reloads on a bit change
   assign phase_nxt = request_to_send_n_i ? '0 : phase_r + phase_inc;
   assign tri_val   = phase_r[23] ? ~phase_r[22:16] : phase_r[22:16];
   assign level_nxt = request_to_send_n_i ? MOD_IDLE_CODE : MOD_LOW_CODE + {1'b0, tri_val};

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         phase_r      <= '0;
         mod_level_o  <= MOD_IDLE_CODE;
         mod_enable_o <= 1'b0;
      end else begin
         phase_r      <= phase_nxt;
         mod_level_o  <= level_nxt;
         mod_enable_o <= !request_to_send_n_i;
      end
   end

   // ****************************************
   // Demodulator
   // ****************************************
   logic        rx_q_r;
   logic [13:0] half_cnt_r;
   logic        demod_r;
   logic        rx_edge;

   assign rx_edge = rx_cmp_i ^ rx_q_r;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rx_q_r     <= 1'b0;
         half_cnt_r <= '0;
         demod_r    <= 1'b0;
      end else begin
         rx_q_r <= rx_cmp_i;
         if (!request_to_send_n_i) begin
            half_cnt_r <= '0;
            demod_r    <= 1'b0;
         end else if (rx_edge) begin
            half_cnt_r <= '0;
            demod_r    <= (half_cnt_r > DEMOD_SPLIT_CYC);
         end else if (half_cnt_r != 14'h3FFF) begin
            half_cnt_r <= half_cnt_r + 14'h0001;
         end
      end
   end

   // ****************************************
   // Carrier detect
   // ****************************************
   logic        cmp_q_r;
   logic [2:0]  pulse_cnt_r;
   logic [31:0] gap_cnt_r;
   logic        cd_r;
   logic        cmp_rise;
   logic        gap_expired;

   assign cmp_rise    = carrier_cmp_i && !cmp_q_r;
   assign gap_expired = (gap_cnt_r == CD_GAP_CYC);

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmp_q_r     <= 1'b0;
         pulse_cnt_r <= '0;
         gap_cnt_r   <= '0;
         cd_r        <= 1'b0;
      end else begin
         cmp_q_r <= carrier_cmp_i;
         if (!request_to_send_n_i) begin
            pulse_cnt_r <= '0;
            gap_cnt_r   <= '0;
            cd_r        <= 1'b0;
         end else if (cmp_rise) begin
            gap_cnt_r <= '0;
            if (pulse_cnt_r == CD_PULSES - 3'h1) begin
               cd_r <= 1'b1;
            end
            if (pulse_cnt_r != CD_PULSES) begin
               pulse_cnt_r <= pulse_cnt_r + 3'h1;
            end
         end else if (gap_expired) begin
            pulse_cnt_r <= '0;
            gap_cnt_r   <= '0;
            cd_r        <= 1'b0;
         end else begin
            gap_cnt_r <= gap_cnt_r + 32'h1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         carrier_present_o  <= 1'b0;
         rx_bit_o           <= 1'b0;
         rx_bit_qualified_o <= 1'b1;
      end else begin
         carrier_present_o  <= cd_r;
         rx_bit_o           <= cd_r && demod_r;
         rx_bit_qualified_o <= !cd_r || demod_r;
      end
   end

   // ****************************************
   // Watchdog and DAC
   // ****************************************
   logic        tick_q_r;
   logic [31:0] int_cnt_r;
   logic [31:0] wdog_cnt_r;
   logic [15:0] sd_acc_r;
   logic [16:0] sd_sum;
   logic        int_kick;
   logic        kick;

   assign int_kick = (int_cnt_r == WDOG_TICK_CYC - 1);
   // kick source picked by config bit
   assign kick     = cfg_r[CFG_WDOG_EXT_BIT] ? (watchdog_tick_i && !tick_q_r) : int_kick;
   // first-order modulator, carry is the bit
   assign sd_sum   = {1'b0, sd_acc_r} + {1'b0, dac_code_r};

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_q_r         <= 1'b0;
         int_cnt_r        <= '0;
         wdog_cnt_r       <= '0;
         watchdog_fault_o <= 1'b0;
         sd_acc_r         <= '0;
         dac_o            <= 1'b0;
      end else begin
         tick_q_r  <= watchdog_tick_i;
         int_cnt_r <= int_kick ? '0 : int_cnt_r + 32'h1;
         if (kick) begin
            wdog_cnt_r       <= '0;
            watchdog_fault_o <= 1'b0;
         end else if (wdog_cnt_r == WDOG_TIMEOUT_CYC) begin
            watchdog_fault_o <= 1'b1;
         end else begin
            wdog_cnt_r <= wdog_cnt_r + 32'h1;
         end
         sd_acc_r <= sd_sum[15:0];
         dac_o    <= watchdog_fault_o ? alarm_level_select_i : sd_sum[16];
      end
   end

   // ****************************************
   // Clock outputs
   // ****************************************
   logic [3:0] div_cnt_r;
   logic [1:0] core_sel;
   logic [1:0] aux_sel;

   assign core_sel = cfg_r[CFG_CORE_DIV_LSB +: 2];
   assign aux_sel  = cfg_r[CFG_AUX_DIV_LSB +: 2];

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt_r    <= '0;
         core_clock_o <= 1'b0;
         aux_clock_o  <= 1'b0;
      end else begin
         div_cnt_r    <= div_cnt_r + 4'h1;
         core_clock_o <= div_cnt_r[core_sel];
         aux_clock_o  <= div_cnt_r[aux_sel];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_tx_steady;
      !request_to_send_n_i [*2];
   endsequence
   sequence s_fourth_pulse;
      request_to_send_n_i && cmp_rise && pulse_cnt_r == 3'h3;
   endsequence

   a_tx_enable: assert property (s_tx_steady |-> mod_enable_o)
      else $error("Modulator off while request low");
   a_idle_level: assert property (
      request_to_send_n_i |=> (mod_level_o == MOD_IDLE_CODE && !mod_enable_o))
      else $error("Transmit level not idle");
   a_mark_step: assert property (
      (!request_to_send_n_i && tx_bit_i) |=> (phase_r - $past(phase_r)) == MARK_INC)
      else $error("Mark step wrong");
   a_phase_cont: assert property (
      (!request_to_send_n_i && $fell(tx_bit_i) && $past(!request_to_send_n_i))
      |=> (phase_r - $past(phase_r)) == SPACE_INC)
      else $error("Phase jump on switch");
   a_demod_mark: assert property (
      (request_to_send_n_i && rx_edge && half_cnt_r > DEMOD_SPLIT_CYC) |=> demod_r)
      else $error("Mark not decoded high");
   a_rx_gated: assert property (!cd_r |=> !rx_bit_o)
      else $error("Receive bit without carrier");
   a_qual_or: assert property (
      rx_bit_qualified_o == (!carrier_present_o || $past(demod_r)))
      else $error("Qualified bit wrong");
   a_cd_four: assert property (
      $rose(cd_r) |-> $past(request_to_send_n_i && cmp_rise && pulse_cnt_r == 3'h3))
      else $error("Carrier rose early");
   a_cd_rise: assert property (s_fourth_pulse |=> cd_r)
      else $error("Carrier missed fourth pulse");
   a_cd_gap: assert property (
      (request_to_send_n_i && !cmp_rise && gap_expired) |=> !cd_r && pulse_cnt_r == 3'h0)
      else $error("Carrier held past gap");
   a_cd_quiet_tx: assert property (!request_to_send_n_i |=> ##1 !carrier_present_o)
      else $error("Carrier during transmit");
   a_alarm_dac: assert property (
      watchdog_fault_o |=> dac_o == $past(alarm_level_select_i))
      else $error("DAC not at alarm level");
   a_wdog_kick: assert property (kick |=> wdog_cnt_r == 32'h0 && !watchdog_fault_o)
      else $error("Kick did not restart watchdog");
   a_sd_bit: assert property (
      (!watchdog_fault_o && sd_sum[16]) |=> dac_o)
      else $error("Modulator bit lost");
endmodule : fsk_modem_pins
`default_nettype wire

// *** inc/modem_pkg.sv ***
`default_nettype none
package modem_pkg;
   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned MARK_HZ         = 1200;
   localparam int unsigned SPACE_HZ        = 2200;
   localparam int unsigned CD_GAP_US       = 2500;
   localparam int unsigned CD_GAP_CYC      = CD_GAP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned WDOG_TICK_HZ    = 1800;
   localparam int unsigned WDOG_TICK_CYC   = CLK_HZ / WDOG_TICK_HZ;
   localparam int unsigned WDOG_TIMEOUT_MS = 10;
   localparam int unsigned WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
   // Half period splitting mark from space, in cycles
   localparam logic [13:0] DEMOD_SPLIT_CYC = 14'(CLK_HZ / (MARK_HZ + SPACE_HZ));
   localparam logic [2:0]  CD_PULSES       = 3'h4;
   localparam logic [7:0]  DAC_UPDATE_CYC  = 8'hFF;

   // ****************************************
   // Tone generator
   // ****************************************
   localparam int          PHASE_W   = 24;
   localparam logic [23:0] MARK_INC  = 24'((64'(MARK_HZ) << PHASE_W) / 64'(CLK_HZ));
   localparam logic [23:0] SPACE_INC = 24'((64'(SPACE_HZ) << PHASE_W) / 64'(CLK_HZ));
   typedef logic [7:0] level_t;
   localparam level_t      MOD_IDLE_CODE = 8'h80;
   localparam level_t      MOD_LOW_CODE  = 8'h40;

   // ****************************************
   // Configuration frames
   // ****************************************
   localparam logic [4:0]  FRAME_SHORT      = 5'h08;
   localparam logic [4:0]  FRAME_LONG       = 5'h10;
   localparam int          FRAME_W          = 17;
   localparam int          FRAME_LONG_BIT   = 16;
   localparam int          FIFO_DEPTH       = 32;
   localparam int          CFG_CORE_DIV_LSB = 1;
   localparam int          CFG_AUX_DIV_LSB  = 3;
   localparam int          CFG_WDOG_EXT_BIT = 5;
   localparam logic [7:0]  CFG_RESET        = 8'h00;
   localparam logic [15:0] DAC_RESET        = 16'h0000;
endpackage : modem_pkg
`default_nettype wire

// *** inc/frame_if.sv ***
`default_nettype none
interface frame_if #(parameter int W = 17);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : frame_if
`default_nettype wire

// *** core/frame_fifo.sv ***
`default_nettype none
module frame_fifo #(
   parameter int W     = 17,
   parameter int DEPTH = 32
) (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   frame_if.snk      in_p,
   frame_if.src      out_p
);
   localparam int AW = $clog2(DEPTH);

   logic [AW:0]  wr_ptr_r;
   logic [AW:0]  rd_ptr_r;
   logic [W-1:0] mem_r [DEPTH];
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   assign full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty = (wr_ptr_r == rd_ptr_r);
   assign push  = in_p.valid && !full;
   assign pop   = out_p.ready && !empty;
   assign in_p.ready  = !full;
   assign out_p.valid = !empty;
   assign out_p.data  = mem_r[rd_ptr_r[AW-1:0]];

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
         rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
      end
   end

   for (genvar g = 0; g < DEPTH; g++) begin : g_entry
      always_ff @(posedge ref_clk_i) begin
         if (push && wr_ptr_r[AW-1:0] == AW'(g)) begin
            mem_r[g] <= in_p.data;
         end
      end
   end
endmodule : frame_fifo
`default_nettype wire

// *** core/cfg_shift.sv ***
`default_nettype none
module cfg_shift (
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic serial_clock_i,
   input  wire logic spi_select_i,
   input  wire logic serial_data_i,
   frame_if.src      out_p,
   output logic      drop_o
);
   import modem_pkg::*;

   logic        sclk_q_r;
   logic        sel_q_r;
   logic [15:0] shift_r;
   logic [4:0]  cnt_r;
   logic        valid_r;
   logic [16:0] data_r;
   logic        sclk_rise;
   logic        frame_end;
   logic        len_ok;
   logic        blocked;

   assign sclk_rise = serial_clock_i && !sclk_q_r;
   assign frame_end = sel_q_r && !spi_select_i;
   assign len_ok    = (cnt_r == FRAME_SHORT) || (cnt_r == FRAME_LONG);
   assign blocked   = valid_r && !out_p.ready;
   assign out_p.valid = valid_r;
   assign out_p.data  = data_r;
   assign drop_o      = frame_end && len_ok && blocked;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_q_r <= 1'b0;
         sel_q_r  <= 1'b0;
         shift_r  <= '0;
         cnt_r    <= '0;
      end else begin
         sclk_q_r <= serial_clock_i;
         sel_q_r  <= spi_select_i;
         // shift in, first bit most significant
         if (!spi_select_i) begin
            cnt_r <= '0;
         end else if (sclk_rise) begin
            shift_r <= {shift_r[14:0], serial_data_i};
            cnt_r   <= (cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h01;
         end
      end
   end

   // Frame held until buffer takes it; a second one meanwhile is lost
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         valid_r <= 1'b0;
         data_r  <= '0;
      end else if (frame_end && len_ok && !blocked) begin
         valid_r <= 1'b1;
         data_r  <= {cnt_r == FRAME_LONG, shift_r};
      end else if (out_p.ready) begin
         valid_r <= 1'b0;
      end
   end

   a_frame_length: assert property (
      @(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(valid_r) |-> ($past(cnt_r) == FRAME_SHORT || $past(cnt_r) == FRAME_LONG))
      else $error("Frame accepted with a bad length");
endmodule : cfg_shift
`default_nettype wire

// *** sim/host_model.sv ***
`default_nettype none
// ****************************************
// Host side of the serial config port
// ****************************************
module host_model (
   input  wire logic ref_clk_i,
   output logic      serial_clock_o,
   output logic      spi_select_o,
   output logic      serial_data_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      serial_clock_o = 1'b0;
      spi_select_o   = 1'b0;
      serial_data_o  = 1'b0;
   end

   task automatic send(input logic [15:0] d, input int n);
      @(negedge ref_clk_i);
      spi_select_o = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_o = d[i];
         @(negedge ref_clk_i);
         serial_clock_o = 1'b1;
         @(negedge ref_clk_i);
         serial_clock_o = 1'b0;
      end
      spi_select_o  = 1'b0;
      // Released line must not look like a held bit
      serial_data_o = ~serial_data_o;
      repeat (2) @(negedge ref_clk_i);
   endtask : send
endmodule : host_model
`default_nettype wire

// *** sim/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import modem_pkg::*;

   logic   clk, rst_b, rts_n, tx_bit, rx_cmp, cd_cmp, alarm, tick, cd_on;
   logic   sclk, sel, sdata;
   logic   mod_en, rx_bit, rx_q, cd, aux_clk, core_clk, dac, wd_fault, drop;
   level_t mod_level;
   int     n_fail, compares, drops, p, e, ones;
   logic [7:0] halves_hi [4] = '{8'h53, 8'h2D, 8'h3C, 8'h39};
   logic       tone_exp  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   // Short counts keep the run within budget
   fsk_modem_pins #(.CD_GAP_CYC(200), .WDOG_TICK_CYC(50), .WDOG_TIMEOUT_CYC(500)) uut (
      .ref_clk_i(clk), .rst_b_i(rst_b), .request_to_send_n_i(rts_n), .tx_bit_i(tx_bit),
      .rx_cmp_i(rx_cmp), .carrier_cmp_i(cd_cmp), .serial_clock_i(sclk),
      .spi_select_i(sel), .serial_data_i(sdata), .alarm_level_select_i(alarm),
      .watchdog_tick_i(tick), .mod_enable_o(mod_en), .mod_level_o(mod_level),
      .rx_bit_o(rx_bit), .rx_bit_qualified_o(rx_q), .carrier_present_o(cd),
      .aux_clock_o(aux_clk), .core_clock_o(core_clk), .dac_o(dac),
      .watchdog_fault_o(wd_fault), .cfg_drop_o(drop));

   host_model hm (.ref_clk_i(clk), .serial_clock_o(sclk), .spi_select_o(sel),
                  .serial_data_o(sdata));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(negedge clk) if (cd_on) cd_cmp <= ~cd_cmp;
   always @(negedge clk) if (drop === 1'b1) drops++;

   // ****************************************
   // Checks and helpers
   // ****************************************
   task automatic chk_bit(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask : chk_bit

   task automatic chk_int(input int got, input int exp, input string what);
      compares++;
      if (got != exp) begin
         n_fail++;
         $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
      end
   endtask : chk_int

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // One level step per 2**16 of phase advance
   function automatic int tone_steps(input logic [23:0] inc, input int n);
      return (n * int'(inc)) / 65536;
   endfunction : tone_steps

   task automatic count_steps(input int n, output int s);
      level_t last;
      s    = 0;
      last = mod_level;
      repeat (n) begin
         @(negedge clk);
         if (mod_level !== last) s++;
         last = mod_level;
      end
   endtask : count_steps

   // Cycles between two rising edges of a divided clock
   task automatic period(input logic aux, output int per);
      logic prev, now;
      int   k;
      per  = 0;
      k    = 0;
      prev = aux ? aux_clk : core_clk;
      while (k < 2 && per < 200) begin
         @(negedge clk);
         now = aux ? aux_clk : core_clk;
         if (now && !prev) k++;
         if (k > 0) per++;
         prev = now;
      end
      per = per - 1;
   endtask : period

   task automatic tally_and_finish;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      // Tests need about 70k cycles
      repeat (90000) @(posedge clk);
      n_fail++;
      $display("BAD %0t watchdog expired", $time);
      tally_and_finish();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      void'($urandom(62));
      rts_n  = 1'b1;
      rst_b  = 1'b0;
      {tx_bit, rx_cmp, cd_cmp, alarm, tick, cd_on} = 6'h00;
      cyc(2);
      chk_bit(rx_q, 1'b1, "reset qual");
      chk_bit(mod_level === MOD_IDLE_CODE, 1'b1, "reset level");
      chk_bit(cd | mod_en | rx_bit | dac | wd_fault | drop, 1'b0, "reset outs");
      chk_bit(aux_clk | core_clk, 1'b0, "reset clocks");
      rst_b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         cyc(3);
         chk_bit(cd, 1'b0, "carrier early");
         cd_cmp = 1'b1;
         cyc(3);
         cd_cmp = 1'b0;
      end
      cyc(3);
      chk_bit(cd, 1'b1, "carrier after four");
      $display("test carrier done");
      cd_on = 1'b1;
      for (int t = 0; t < 4; t++) begin
         repeat (2) begin
            cyc(int'(halves_hi[t]) * 100 + 33);
            rx_cmp = ~rx_cmp;
         end
         cyc(4);
         chk_bit(rx_bit, tone_exp[t], "demod bit");
         chk_bit(rx_q, tone_exp[t], "demod qual");
         chk_bit(cd, 1'b1, "carrier held");
      end
      $display("test demod done");
      cd_on = 1'b0;
      cyc(150);
      chk_bit(cd, 1'b1, "carrier in gap");
      cyc(100);
      chk_bit(cd, 1'b0, "carrier lost");
      chk_bit(rx_bit, 1'b0, "rx gated");
      chk_bit(rx_q, 1'b1, "qual forced");
      cd_on = 1'b1;
      cyc(20);
      chk_bit(cd, 1'b1, "carrier regained");
      rts_n = 1'b0;
      cyc(3);
      chk_bit(cd, 1'b0, "carrier in tx");
      chk_bit(mod_en, 1'b1, "mod on");
      repeat (300) begin
         tx_bit = 1'($urandom);
         cyc(1);
         chk_bit(mod_level >= MOD_LOW_CODE && mod_level <= MOD_LOW_CODE + 8'h7F, 1'b1,
                 "tx swing");
      end
      tx_bit = 1'b1;
      cyc(2);
      count_steps(600, p);
      e = tone_steps(MARK_INC, 600);
      chk_bit(p >= e - 2 && p <= e + 1, 1'b1, "mark rate");
      tx_bit = 1'b0;
      cyc(2);
      count_steps(600, p);
      e = tone_steps(SPACE_INC, 600);
      chk_bit(p >= e - 2 && p <= e + 1, 1'b1, "space rate");
      rts_n = 1'b1;
      cd_on = 1'b0;
      cyc(3);
      chk_bit(mod_en, 1'b0, "mod off");
      chk_bit(mod_level === MOD_IDLE_CODE, 1'b1, "idle level");
      $display("test transmit done");
      for (int f = 0; f < 4; f++) begin
         hm.send({8'h00, 3'h0, 2'(3 - f), 2'(f), 1'b0}, 8);
         cyc(300);
         period(1'b0, p);
         chk_int(p, 2 << f, "core div");
         period(1'b1, p);
         chk_int(p, 2 << (3 - f), "aux div");
      end
      hm.send(16'h0000, 7);
      hm.send(16'h4000, 16);
      cyc(300);
      period(1'b0, p);
      chk_int(p, 16, "odd frame dropped");
      ones = 0;
      repeat (1024) begin
         cyc(1);
         ones += int'(dac === 1'b1);
      end
      chk_bit(ones >= 248 && ones <= 264, 1'b1, "dac density");
      $display("test config done");
      for (int a = 0; a < 2; a++) begin
         alarm = 1'(a);
         hm.send(16'h0020, 8);
         cyc(1000);
         chk_bit(wd_fault, 1'b1, "fault no kick");
         chk_bit(dac, 1'(a), "alarm level");
         tick = 1'b1;
         cyc(2);
         tick = 1'b0;
         cyc(3);
         chk_bit(wd_fault, 1'b0, "kick clears");
      end
      hm.send(16'h0000, 8);
      cyc(1000);
      chk_bit(wd_fault, 1'b0, "internal kick");
      $display("test watchdog done");
      drops = 0;
      repeat (40) hm.send({8'h00, 8'($urandom) & 8'hDF}, 8);
      cyc(5);
      chk_bit(drops > 0 && drops < 9, 1'b1, "fifo overflow");
      cyc(256 * 34);
      hm.send(16'h0002, 8);
      cyc(300);
      period(1'b0, p);
      chk_int(p, 4, "fifo drained");
      $display("test fifo done");
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
